// ===== rtl/hud_pkg.sv
// Constants, types and the baud table for the dual-mode host serial block.
// Assumes a single 50 MHz system clock; all users reference hud_pkg::name.
package hud_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int NUM_PORTS = 2;
  localparam int CMD_PORT = 0;
  localparam int DATA_PORT = 1;

  localparam int DIV_W = 18;
  localparam int RATE_W = 5;
  localparam int NUM_RATES = 18;
  localparam int RATES [NUM_RATES] = '{
    300, 600, 1_200, 2_400, 4_800, 9_600, 14_400, 19_200, 28_800,
    38_400, 56_000, 57_600, 115_200, 128_000, 256_000, 520_000, 780_000, 1_500_000};
  localparam logic [RATE_W-1:0] RATE_DEFAULT = 5'h0c;

  localparam int DATA_MAX = 8;
  localparam int BITS_BASE = 5;
  localparam int FRAME_W = 12;
  localparam int LEN_W = 4;
  localparam logic [1:0] BITS_DEFAULT = 2'h3;
  localparam logic [DATA_MAX-1:0] DATA_ONES = 8'hff;
  localparam logic STOP2_DEFAULT = 1'h0;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD = 2'b10
  } hud_par_type;
  localparam logic [1:0] PAR_DEFAULT = 2'h0;

  // Boot time to firmware-ready: typical figure used, below the maximum
  localparam int READY_TYP_S = 4;
  localparam int READY_MAX_S = 5;
  localparam int READY_CYCLES = READY_TYP_S * CLK_HZ;
  localparam int READY_W = 28;

  typedef enum logic [2:0] {
    MODE_BOOT = 3'b000,
    MODE_ARM = 3'b001,
    MODE_BIN = 3'b010,
    MODE_CMD_SET = 3'b011,
    MODE_CMD = 3'b100,
    MODE_BIN_SET = 3'b101
  } hud_mode_type;

  typedef struct packed {
    logic [LEN_W-1:0] tx_left;
    logic [DIV_W-1:0] tx_cnt;
    logic [FRAME_W-1:0] tx_frm;
    logic [LEN_W-1:0] rx_left;
    logic [LEN_W-1:0] rx_idx;
    logic [DIV_W-1:0] rx_cnt;
    logic [FRAME_W-1:0] rx_frm;
    logic [DATA_MAX-1:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
  } hud_uart_state_type;

  typedef struct packed {
    hud_mode_type mode;
    logic [READY_W-1:0] ready_cnt;
    logic ready;
    logic stat;
    logic tgl_prev;
    logic dual_en;
    logic [NUM_PORTS-1:0][RATE_W-1:0] baud_sel;
    logic [NUM_PORTS-1:0][1:0] bits;
    logic [NUM_PORTS-1:0][1:0] par;
    logic [NUM_PORTS-1:0] two_stop;
  } hud_top_state_type;

  // Rounded clock divisor; unsupported indices fall back to the default rate
  function automatic logic [DIV_W-1:0] baud_div(input logic [RATE_W-1:0] sel);
    int r;
    r = (int'(sel) < NUM_RATES) ? RATES[sel] : RATES[RATE_DEFAULT];
    return DIV_W'((CLK_HZ + r / 2) / r);
  endfunction : baud_div

endpackage : hud_pkg

// ===== rtl/hud_uart.sv
// One full-duplex serial engine: frame shifter for transmit, mid-bit sampler for receive.
// Assumes i_rxd is synchronous to i_sys_clk and config is stable during a frame.
`timescale 1ns/100ps
`default_nettype none
module hud_uart (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Frame format
  input wire logic [hud_pkg::DIV_W-1:0] i_div,
  input wire logic [1:0] i_bits,
  input wire logic [1:0] i_par,
  input wire logic i_two_stop,
  // Transmit
  input wire logic [hud_pkg::DATA_MAX-1:0] i_tx_data,
  input wire logic i_tx_valid,
  input wire logic i_tx_allow,
  output logic o_tx_ready,
  output logic o_txd,
  // Receive
  input wire logic i_rxd,
  input wire logic i_rx_ack,
  output logic [hud_pkg::DATA_MAX-1:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_perr,
  output logic o_rx_ferr
);

  hud_pkg::hud_uart_state_type s;
  hud_pkg::hud_uart_state_type next_s;

  logic pe;
  logic odd;
  logic [hud_pkg::LEN_W-1:0] nbits;
  logic [hud_pkg::LEN_W-1:0] len;
  logic [hud_pkg::DATA_MAX-1:0] mask;
  logic [hud_pkg::FRAME_W-1:0] frame;
  logic [hud_pkg::DATA_MAX-1:0] tx_masked;

  always_comb begin
    pe = (i_par == hud_pkg::PAR_EVEN) || (i_par == hud_pkg::PAR_ODD);
    odd = (i_par == hud_pkg::PAR_ODD);
    nbits = hud_pkg::LEN_W'(hud_pkg::BITS_BASE) + {2'h0, i_bits};
    len = hud_pkg::LEN_W'(nbits + 4'h2 + {3'h0, pe} + {3'h0, i_two_stop});
    mask = hud_pkg::DATA_ONES >> (2'h3 - i_bits);
    tx_masked = i_tx_data & mask;
    // Unused upper positions stay one, so the line idles high after the stops
    frame = '1;
    frame[0] = 1'b0;
    frame[hud_pkg::DATA_MAX:1] = ~mask | tx_masked;
    if (pe) begin
      frame[nbits + 4'h1] = ^tx_masked ^ odd;
    end
  end

  assign o_tx_ready = (s.tx_left == '0) && i_tx_allow;
  assign o_txd = s.tx_frm[0];
  assign o_rx_data = s.rx_data;
  assign o_rx_valid = s.rx_valid;
  assign o_rx_perr = s.rx_perr;
  assign o_rx_ferr = s.rx_ferr;

  always_comb begin
    next_s = s;
    // Transmit: shift the whole frame LSB first, one bit per divisor period
    if (s.tx_left == '0) begin
      if (i_tx_valid && i_tx_allow) begin
        next_s.tx_frm = frame;
        next_s.tx_left = len;
        next_s.tx_cnt = i_div - 1'b1;
      end
    end else if (s.tx_cnt == '0) begin
      next_s.tx_frm = {1'b1, s.tx_frm[hud_pkg::FRAME_W-1:1]};
      next_s.tx_left = s.tx_left - 1'b1;
      next_s.tx_cnt = i_div - 1'b1;
    end else begin
      next_s.tx_cnt = s.tx_cnt - 1'b1;
    end
    // Ack clears first so a frame completing in the same cycle still sets
    if (i_rx_ack) begin
      next_s.rx_valid = 1'b0;
    end
    if (s.rx_left == '0) begin
      if (!i_rxd) begin
        next_s.rx_left = len;
        next_s.rx_idx = '0;
        next_s.rx_cnt = i_div >> 1;
      end
    end else if (s.rx_cnt == '0) begin
      next_s.rx_frm[s.rx_idx] = i_rxd;
      next_s.rx_idx = s.rx_idx + 1'b1;
      next_s.rx_left = s.rx_left - 1'b1;
      next_s.rx_cnt = i_div - 1'b1;
      if (s.rx_idx == '0 && i_rxd) begin
        // Glitch, not a start bit
        next_s.rx_left = '0;
      end else if (s.rx_left == 4'h1) begin
        // Decision at mid last stop bit lets the next start be caught early
        next_s.rx_data = next_s.rx_frm[hud_pkg::DATA_MAX:1] & mask;
        next_s.rx_perr = pe && ((^(next_s.rx_frm[hud_pkg::DATA_MAX:1] & mask)
                         ^ next_s.rx_frm[nbits + 4'h1]) != odd);
        next_s.rx_ferr = !next_s.rx_frm[nbits + 4'h1 + {3'h0, pe}];
        next_s.rx_valid = 1'b1;
      end
    end else begin
      next_s.rx_cnt = s.rx_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{tx_frm: '1, rx_frm: '1, default: '0};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

endmodule : hud_uart
`default_nettype wire

// ===== rtl/hud_top.sv
// Host serial interface: command port, data port with binary/command switching.
// Assumes host pins are synchronous to i_sys_clk; configuration arrives as plain ports.
`timescale 1ns/100ps
`default_nettype none
module hud_top #(
  parameter int P_READY_CYCLES = hud_pkg::READY_CYCLES
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Stored user configuration write
  input wire logic i_cfg_wr,
  input wire logic i_cfg_port,
  input wire logic [hud_pkg::RATE_W-1:0] i_cfg_baud_sel,
  input wire logic [1:0] i_cfg_data_bits,
  input wire logic [1:0] i_cfg_parity,
  input wire logic i_cfg_two_stop,
  input wire logic i_cfg_dual_en,
  // Status
  output logic o_fw_ready,
  output logic o_iface_state,
  output logic o_data_cmd_mode,
  // Command serial port pins
  input wire logic i_cmd_rxd,
  output logic o_cmd_txd,
  // Command serial port user side
  input wire logic [hud_pkg::DATA_MAX-1:0] i_cmd_tx_data,
  input wire logic i_cmd_tx_valid,
  output logic o_cmd_tx_ready,
  output logic [hud_pkg::DATA_MAX-1:0] o_cmd_rx_data,
  output logic o_cmd_rx_valid,
  input wire logic i_cmd_rx_ack,
  output logic o_cmd_rx_perr,
  output logic o_cmd_rx_ferr,
  // Data serial port pins
  input wire logic i_data_rxd,
  output logic o_data_txd,
  input wire logic i_data_rts_n,
  output logic o_data_cts_n,
  input wire logic i_interface_select_toggle,
  // Data serial port user side
  input wire logic [hud_pkg::DATA_MAX-1:0] i_data_tx_data,
  input wire logic i_data_tx_valid,
  output logic o_data_tx_ready,
  output logic [hud_pkg::DATA_MAX-1:0] o_data_rx_data,
  output logic o_data_rx_valid,
  input wire logic i_data_rx_ack,
  output logic o_data_rx_perr,
  output logic o_data_rx_ferr
);

  hud_pkg::hud_top_state_type s;
  hud_pkg::hud_top_state_type next_s;

  logic tgl_rise;
  logic tgl_fall;
  logic [hud_pkg::NUM_PORTS-1:0] rxd;
  logic [hud_pkg::NUM_PORTS-1:0] txd;
  logic [hud_pkg::NUM_PORTS-1:0] tx_allow;
  logic [hud_pkg::NUM_PORTS-1:0] tx_valid;
  logic [hud_pkg::NUM_PORTS-1:0] tx_ready;
  logic [hud_pkg::NUM_PORTS-1:0][hud_pkg::DATA_MAX-1:0] tx_data;
  logic [hud_pkg::NUM_PORTS-1:0][hud_pkg::DATA_MAX-1:0] rx_data;
  logic [hud_pkg::NUM_PORTS-1:0] rx_valid;
  logic [hud_pkg::NUM_PORTS-1:0] rx_ack;
  logic [hud_pkg::NUM_PORTS-1:0] rx_perr;
  logic [hud_pkg::NUM_PORTS-1:0] rx_ferr;

  assign tgl_rise = i_interface_select_toggle && !s.tgl_prev;
  assign tgl_fall = !i_interface_select_toggle && s.tgl_prev;

  always_comb begin
    next_s = s;
    next_s.tgl_prev = i_interface_select_toggle;
    if (i_cfg_wr) begin
      // Data port keeps one format whether plain or dual
      next_s.baud_sel[i_cfg_port] = i_cfg_baud_sel;
      next_s.bits[i_cfg_port] = i_cfg_data_bits;
      next_s.par[i_cfg_port] = i_cfg_parity;
      next_s.two_stop[i_cfg_port] = i_cfg_two_stop;
      next_s.dual_en = i_cfg_dual_en;
    end
    case (s.mode)
      hud_pkg::MODE_BOOT: begin
        next_s.ready_cnt = s.ready_cnt + 1'b1;
        if (s.ready_cnt == hud_pkg::READY_W'(P_READY_CYCLES - 1)) begin
          next_s.ready = 1'b1;
          next_s.mode = hud_pkg::MODE_ARM;
        end
      end
      hud_pkg::MODE_ARM: begin
        // Start condition only counts once ready is high
        if (tgl_fall && s.dual_en) begin
          next_s.mode = hud_pkg::MODE_BIN;
        end
      end
      hud_pkg::MODE_BIN: begin
        if (tgl_rise && s.dual_en) begin
          next_s.stat = 1'b0;
          next_s.mode = hud_pkg::MODE_CMD_SET;
        end
      end
      hud_pkg::MODE_CMD_SET: begin
        if (tgl_fall) begin
          next_s.mode = hud_pkg::MODE_CMD;
        end
      end
      hud_pkg::MODE_CMD: begin
        if (tgl_rise) begin
          next_s.stat = 1'b1;
          next_s.mode = hud_pkg::MODE_BIN_SET;
        end
      end
      hud_pkg::MODE_BIN_SET: begin
        if (tgl_fall) begin
          next_s.mode = hud_pkg::MODE_BIN;
        end
      end
      default: begin
        next_s.mode = hud_pkg::MODE_BOOT;
        next_s.stat = 1'b1;
      end
    endcase
    // Disabling dual use drops straight back to a plain binary channel
    if (!s.dual_en && s.mode != hud_pkg::MODE_BOOT) begin
      next_s.mode = hud_pkg::MODE_ARM;
      next_s.stat = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{
        mode: hud_pkg::MODE_BOOT,
        ready_cnt: '0,
        ready: 1'b0,
        stat: 1'b1,
        tgl_prev: 1'b1,
        dual_en: 1'b0,
        baud_sel: {hud_pkg::NUM_PORTS{hud_pkg::RATE_DEFAULT}},
        bits: {hud_pkg::NUM_PORTS{hud_pkg::BITS_DEFAULT}},
        par: {hud_pkg::NUM_PORTS{hud_pkg::PAR_DEFAULT}},
        two_stop: {hud_pkg::NUM_PORTS{hud_pkg::STOP2_DEFAULT}}
      };
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_fw_ready = s.ready;
  assign o_iface_state = s.stat;
  assign o_data_cmd_mode = !s.stat;

  // Nothing leaves before firmware is ready; data port also honours the host's handshake
  assign tx_allow = {s.ready && !i_data_rts_n, s.ready};
  assign o_data_cts_n = rx_valid[hud_pkg::DATA_PORT];

  assign rxd = {i_data_rxd, i_cmd_rxd};
  assign tx_valid = {i_data_tx_valid, i_cmd_tx_valid};
  assign tx_data = {i_data_tx_data, i_cmd_tx_data};
  assign rx_ack = {i_data_rx_ack, i_cmd_rx_ack};
  assign o_cmd_txd = txd[hud_pkg::CMD_PORT];
  assign o_data_txd = txd[hud_pkg::DATA_PORT];
  assign o_cmd_tx_ready = tx_ready[hud_pkg::CMD_PORT];
  assign o_data_tx_ready = tx_ready[hud_pkg::DATA_PORT];
  assign o_cmd_rx_data = rx_data[hud_pkg::CMD_PORT];
  assign o_data_rx_data = rx_data[hud_pkg::DATA_PORT];
  assign o_cmd_rx_valid = rx_valid[hud_pkg::CMD_PORT];
  assign o_data_rx_valid = rx_valid[hud_pkg::DATA_PORT];
  assign o_cmd_rx_perr = rx_perr[hud_pkg::CMD_PORT];
  assign o_data_rx_perr = rx_perr[hud_pkg::DATA_PORT];
  assign o_cmd_rx_ferr = rx_ferr[hud_pkg::CMD_PORT];
  assign o_data_rx_ferr = rx_ferr[hud_pkg::DATA_PORT];

  for (genvar p = 0; p < hud_pkg::NUM_PORTS; p++) begin : g_port
    hud_uart u_uart (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_div(hud_pkg::baud_div(s.baud_sel[p])),
      .i_bits(s.bits[p]),
      .i_par(s.par[p]),
      .i_two_stop(s.two_stop[p]),
      .i_tx_data(tx_data[p]),
      .i_tx_valid(tx_valid[p]),
      .i_tx_allow(tx_allow[p]),
      .o_tx_ready(tx_ready[p]),
      .o_txd(txd[p]),
      .i_rxd(rxd[p]),
      .i_rx_ack(rx_ack[p]),
      .o_rx_data(rx_data[p]),
      .o_rx_valid(rx_valid[p]),
      .o_rx_perr(rx_perr[p]),
      .o_rx_ferr(rx_ferr[p])
    );
  end

endmodule : hud_top
`default_nettype wire

// ===== tb/hud_monitor.sv
// Port checker for hud_top: toggle states, boot delay, flow control.
// Assumes one clock domain; bound to every hud_top below.
`timescale 1ns/100ps
`default_nettype none
module hud_monitor #(
  parameter int P_READY_CYCLES = 20
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Inputs watched
  input wire logic i_cfg_wr,
  input wire logic i_cfg_dual_en,
  input wire logic i_interface_select_toggle,
  input wire logic i_data_tx_valid,
  input wire logic i_data_rts_n,
  input wire logic i_data_rx_ack,
  // Outputs watched
  input wire logic o_fw_ready,
  input wire logic o_iface_state,
  input wire logic o_cmd_txd,
  input wire logic o_cmd_tx_ready,
  input wire logic o_data_txd,
  input wire logic o_data_tx_ready,
  input wire logic o_data_cts_n,
  input wire logic o_data_rx_valid
);
  logic tgl_q, dual_q, started, rise, fall;
  int boot_cnt;
  assign rise = i_ce && i_interface_select_toggle && !tgl_q;
  assign fall = i_ce && !i_interface_select_toggle && tgl_q;
  // Start fall only counts once ready and enabled
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tgl_q <= 1'b1;
      dual_q <= 1'b0;
      started <= 1'b0;
      boot_cnt <= 0;
    end else if (i_ce) begin
      tgl_q <= i_interface_select_toggle;
      dual_q <= i_cfg_wr ? i_cfg_dual_en : dual_q;
      boot_cnt <= (boot_cnt < P_READY_CYCLES) ? boot_cnt + 1 : boot_cnt;
      started <= dual_q && (started || (fall && o_fw_ready));
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_to_cmd;
    started && dual_q && o_fw_ready && o_iface_state && rise;
  endsequence
  sequence s_to_bin;
    started && dual_q && o_fw_ready && !o_iface_state && rise;
  endsequence
  AST_TO_CMD: assert property (s_to_cmd |=> !o_iface_state)
    else $error("toggle rise did not enter command state");
  AST_TO_BIN: assert property (s_to_bin |=> o_iface_state)
    else $error("toggle rise did not return to binary state");
  AST_STATE_CAUSE: assert property (!$stable(o_iface_state) |-> $past(rise) || !$past(dual_q))
    else $error("state output changed without a toggle rise");
  AST_NO_DUAL: assert property (!dual_q && i_ce |=> o_iface_state)
    else $error("state left binary while dual mode is off");
  AST_BOOT: assert property (o_fw_ready == (boot_cnt == P_READY_CYCLES))
    else $error("ready output at the wrong cycle");
  AST_READY_GATE: assert property (!o_fw_ready |-> !o_cmd_tx_ready && !o_data_tx_ready && o_iface_state)
    else $error("activity before ready");
  AST_TX_START: assert property (i_ce && i_data_tx_valid && o_data_tx_ready |=> (!o_data_txd && !o_data_tx_ready) [*2])
    else $error("start bit missing after transmit take");
  AST_RTS: assert property (i_data_rts_n |-> !o_data_tx_ready)
    else $error("transmit offered while host not ready");
  AST_CTS: assert property ($fell(o_data_cts_n) |-> $past(i_data_rx_ack) && !o_data_rx_valid)
    else $error("clear to send freed without an acknowledge");
  AST_TXD_IDLE: assert property (o_cmd_tx_ready |-> o_cmd_txd)
    else $error("idle line not high");
endmodule : hud_monitor
bind hud_top hud_monitor #(.P_READY_CYCLES(P_READY_CYCLES)) u_monitor (
  .i_sys_clk, .i_rst, .i_ce, .i_cfg_wr, .i_cfg_dual_en, .i_interface_select_toggle,
  .i_data_tx_valid, .i_data_rts_n, .i_data_rx_ack, .o_fw_ready, .o_iface_state, .o_cmd_txd,
  .o_cmd_tx_ready, .o_data_txd, .o_data_tx_ready, .o_data_cts_n, .o_data_rx_valid
);
`default_nettype wire

// ===== tb/hud_host_model.sv
// Host partner on the data port: frames, select toggle, flow control.
// Assumes the bench calls its tasks; outputs change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module hud_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Device side
  input wire logic i_txd,
  input wire logic i_cts_n,
  output logic o_rxd,
  output logic o_rts_n,
  output logic o_toggle
);
  initial begin
    o_rxd = 1'b1;
    o_rts_n = 1'b0;
    o_toggle = 1'b1;
  end
  task automatic set_tgl(input logic v);
    @(posedge i_sys_clk);
    o_toggle <= v;
  endtask : set_tgl
  task automatic set_rts(input logic v);
    @(posedge i_sys_clk);
    o_rts_n <= v;
  endtask : set_rts
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input int div);
    logic p;
    p = par[1];
    for (int n = 0; n < 5000 && i_cts_n !== 1'b0; n++) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_rxd <= 1'b0;
    repeat (div) @(posedge i_sys_clk);
    for (int i = 0; i < nb; i++) begin
      o_rxd <= d[i];
      p = p ^ d[i];
      repeat (div) @(posedge i_sys_clk);
    end
    if (par != 2'h0) begin
      o_rxd <= p;
      repeat (div) @(posedge i_sys_clk);
    end
    o_rxd <= 1'b1;
    repeat (div) @(posedge i_sys_clk);
  endtask : send
  // Mid-bit sampling on the falling edge keeps clear of the launch edge
  task automatic recv(input int nb, input logic [1:0] par, input int div,
                      output logic [7:0] d, output logic ok);
    logic p;
    p = par[1];
    d = 8'h00;
    for (int n = 0; n < 5000 && i_txd !== 1'b0; n++) @(negedge i_sys_clk);
    repeat (div / 2) @(negedge i_sys_clk);
    ok = (i_txd === 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(negedge i_sys_clk);
      d[i] = i_txd;
      p = p ^ i_txd;
    end
    if (par != 2'h0) begin
      repeat (div) @(negedge i_sys_clk);
      ok = ok && (i_txd === p);
    end
    repeat (div) @(negedge i_sys_clk);
    ok = ok && (i_txd === 1'b1);
  endtask : recv
endmodule : hud_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for hud_top: formats, dual toggle, flow control.
// Assumes the host model on the data port and a command port loopback.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int P_RDY = 20;
  localparam int DIV = (hud_pkg::CLK_HZ + 750_000) / 1_500_000;
  localparam int DEF = (hud_pkg::CLK_HZ + 57_600) / 115_200;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_cfg_wr = 1'b0, i_cfg_port = 1'b0;
  logic i_cfg_two_stop = 1'b0, i_cfg_dual_en = 1'b0, i_ce = 1'b1, ok;
  logic [hud_pkg::RATE_W-1:0] i_cfg_baud_sel = 5'h11;
  logic [1:0] i_cfg_data_bits = 2'h3, i_cfg_parity = 2'h0;
  logic [7:0] i_cmd_tx_data = 8'h00, i_data_tx_data = 8'h00, o_cmd_rx_data, o_data_rx_data, got;
  logic i_cmd_tx_valid = 1'b0, i_data_tx_valid = 1'b0, i_cmd_rx_ack = 1'b0, i_data_rx_ack = 1'b0;
  logic o_fw_ready, o_iface_state, o_data_cmd_mode, o_cmd_txd, o_cmd_tx_ready, o_cmd_rx_valid;
  logic o_cmd_rx_perr, o_cmd_rx_ferr, o_data_txd, o_data_cts_n, o_data_tx_ready;
  logic o_data_rx_valid, o_data_rx_perr, o_data_rx_ferr, rxd, rts_n, tgl;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  hud_top #(.P_READY_CYCLES(P_RDY)) dut (
    .i_sys_clk, .i_rst, .i_ce, .i_cfg_wr, .i_cfg_port, .i_cfg_baud_sel,
    .i_cfg_data_bits, .i_cfg_parity, .i_cfg_two_stop, .i_cfg_dual_en, .o_fw_ready,
    .o_iface_state, .o_data_cmd_mode, .i_cmd_rxd(o_cmd_txd), .o_cmd_txd, .i_cmd_tx_data,
    .i_cmd_tx_valid, .o_cmd_tx_ready, .o_cmd_rx_data, .o_cmd_rx_valid, .i_cmd_rx_ack,
    .o_cmd_rx_perr, .o_cmd_rx_ferr, .i_data_rxd(rxd), .o_data_txd, .i_data_rts_n(rts_n),
    .o_data_cts_n, .i_interface_select_toggle(tgl), .i_data_tx_data, .i_data_tx_valid,
    .o_data_tx_ready, .o_data_rx_data, .o_data_rx_valid, .i_data_rx_ack, .o_data_rx_perr,
    .o_data_rx_ferr
  );
  hud_host_model host (
    .i_sys_clk, .i_txd(o_data_txd), .i_cts_n(o_data_cts_n), .o_rxd(rxd), .o_rts_n(rts_n),
    .o_toggle(tgl)
  );
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : tick
  task automatic cfg(input logic port, input logic [1:0] bits, input logic [1:0] par,
                     input logic two);
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_port <= port;
    i_cfg_data_bits <= bits;
    i_cfg_parity <= par;
    i_cfg_two_stop <= two;
    i_cfg_dual_en <= 1'b1;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
  endtask : cfg
  task automatic tx(input logic port, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_cmd_tx_data <= d;
    i_data_tx_data <= d;
    i_cmd_tx_valid <= !port;
    i_data_tx_valid <= port;
    do begin
      tick(1);
      n++;
    end while ((port ? o_data_tx_ready : o_cmd_tx_ready) !== 1'b1 && n < 5000);
    @(posedge i_sys_clk);
    i_cmd_tx_valid <= 1'b0;
    i_data_tx_valid <= 1'b0;
  endtask : tx
  task automatic rx_ack(input logic port);
    for (int n = 0; n < 1000 && (port ? o_data_rx_valid : o_cmd_rx_valid) !== 1'b1; n++) tick(1);
    chk("rx valid", 1'b1, port ? o_data_rx_valid : o_cmd_rx_valid);
    chk("cts busy", port, o_data_cts_n);
    @(posedge i_sys_clk);
    i_cmd_rx_ack <= !port;
    i_data_rx_ack <= port;
    @(posedge i_sys_clk);
    i_cmd_rx_ack <= 1'b0;
    i_data_rx_ack <= 1'b0;
    tick(1);
    chk("cts free", 1'b0, o_data_cts_n);
  endtask : rx_ack
  task automatic tgl_seq(input logic [5:0] exp);
    for (int k = 0; k < 6; k++) begin
      host.set_tgl(!k[0]);
      tick(2);
      chk("iface state", exp[k], o_iface_state);
      chk("cmd mode", !exp[k], o_data_cmd_mode);
    end
  endtask : tgl_seq
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    tick(P_RDY);
    chk("ready early", 1'b0, o_fw_ready);
    tick(1);
    chk("ready", 1'b1, o_fw_ready);
    $display("test boot done");
    tgl_seq(6'b111111);
    fork
      host.recv(8, 2'h0, DEF, got, ok);
      tx(1'b1, 8'h5a);
    join
    chk("default frame", 8'h5a, got);
    chk("default stop", 1'b1, ok);
    $display("test defaults done");
    cfg(1'b1, 2'h3, 2'h0, 1'b0);
    tgl_seq(6'b110011);
    // A rise while frozen must only take effect once the enable returns
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    host.set_tgl(1'b1);
    tick(4);
    chk("frozen state", 1'b1, o_iface_state);
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    tick(2);
    chk("thawed state", 1'b0, o_iface_state);
    host.set_tgl(1'b0);
    host.set_tgl(1'b1);
    host.set_tgl(1'b0);
    tick(2);
    chk("back to binary", 1'b1, o_iface_state);
    $display("test toggle done");
    for (int f = 0; f < 4; f++) begin
      cfg(1'b1, 2'(f), 2'(f % 3), f == 3);
      fork
        host.recv(5 + f, 2'(f % 3), DIV, got, ok);
        tx(1'b1, 8'hb6);
      join
      chk("tx data", 8'hb6 & (8'hff >> (3 - f)), got);
      chk("tx frame", 1'b1, ok);
    end
    host.set_rts(1'b1);
    fork
      begin
        tick(100);
        chk("stalled line", 1'b1, o_data_txd);
        host.set_rts(1'b0);
      end
      host.recv(8, 2'h0, DIV, got, ok);
      tx(1'b1, 8'h3c);
    join
    chk("after stall", 8'h3c, got);
    $display("test transmit done");
    cfg(1'b1, 2'h2, 2'h2, 1'b0);
    for (int p = 1; p < 3; p++) begin
      host.send(8'hda, 7, 2'(p), DIV);
      chk("rx parity", p == 1, o_data_rx_perr);
      chk("rx framing", 1'b0, o_data_rx_ferr);
      chk("rx data", 8'h5a, o_data_rx_data);
      rx_ack(1'b1);
    end
    $display("test receive done");
    cfg(1'b0, 2'h3, 2'h1, 1'b0);
    tx(1'b0, 8'hc3);
    rx_ack(1'b0);
    chk("cmd data", 8'hc3, o_cmd_rx_data);
    chk("cmd parity", 1'b0, o_cmd_rx_perr);
    chk("cmd framing", 1'b0, o_cmd_rx_ferr);
    $display("test command port done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
